// ---- rtl/led_matrix_pkg.sv ----
// Shared constants and types for the three by three LED matrix row scanner
package led_matrix_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Matrix geometry
  localparam int ROWS = 3;
  localparam int COLS = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: scan tick period in its own unit, cycle count derived from the clock
  localparam int CLK_PERIOD_NS    = 8;
  localparam int NS_PER_MS        = 1000000;
  localparam int SCAN_TICK_MS     = 5;
  localparam int SCAN_TICK_CYCLES = SCAN_TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int FRAME_HOLD_TICKS = 100;
  localparam int FRAME_CNT_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Pin word layout: rows in bits 2:0, columns in bits 5:3
  localparam logic [5:0] COL_MASK    = 6'h38;
  localparam int         COL_LSB     = 3;
  localparam logic [2:0] ROW_IDLE_N  = 3'h7;
  localparam logic [2:0] COL_RESET   = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Row patterns, bit 0 is the right-most column
  localparam logic [2:0] PAT_FULL = 3'h7;
  localparam logic [2:0] PAT_MID  = 3'h2;
  localparam logic [2:0] PAT_DARK = 3'h0;

  typedef logic [COLS-1:0] col_pattern_t;
  typedef col_pattern_t [ROWS-1:0] pattern_table_t;

  typedef enum logic [1:0] {
    ROW_FIRST,
    ROW_SECOND,
    ROW_THIRD
  } row_state_t;

  typedef struct packed {
    logic [COLS-1:0] col;
    logic [ROWS-1:0] row_n;
  } matrix_pins_t;

  // Frames as whole tables, entry 0 is the top row
  localparam pattern_table_t FRAME_T     = {PAT_MID, PAT_MID, PAT_FULL};
  localparam pattern_table_t FRAME_I     = {PAT_FULL, PAT_MID, PAT_FULL};
  localparam pattern_table_t FRAME_BLANK = {PAT_DARK, PAT_DARK, PAT_DARK};

endpackage

// ---- rtl/scan_tick_gen.sv ----
// Periodic one-cycle scan tick derived from the system clock
`timescale 1ns/1ps
module scan_tick_gen #(
  parameter int CYCLES = 625000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  output logic      o_tick
);

  localparam int CNT_W = $clog2(CYCLES);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_tick;

  // Free running divider, pulse on the wrap so spacing is exactly CYCLES
  always_comb begin
    next_tick  = (count == LAST);
    next_count = next_tick ? '0 : count + CNT_W'(1);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      count  <= next_count;
      o_tick <= next_tick;
    end
  end

endmodule

// ---- rtl/led_matrix_row_scanner.sv ----
// Row scanner and frame sequencer for a three by three LED matrix
//
// Summary of operation
// - After reset the first row is the next row to drive.
// - Each tick steps the row first, second, third, then wraps to first.
// - Each tick drives the current row and releases the previous one.
// - Each tick loads columns from the current row's table entry under mask.
// - Table bit one lights the LED, zero keeps it dark.
// - Table is rewritten at one to four multiples of the frame hold count, then the cycle repeats.
// - First frame is dark; at one hold count a T: top row full, other rows middle only.
// - At two and four hold counts the table clears for one dark frame.
// - At three hold counts the table shows an I shape.
// - Counter beyond four hold counts clears to zero and sequence restarts.
// - Rows are active low, columns active high.
// - Tick every 5 ms; a frame is held for 100 ticks.
// - Column writes touch only mask 0x38 bits of the pin word.
`timescale 1ns/1ps
module led_matrix_row_scanner
  import led_matrix_pkg::*;
#(
  parameter int TICK_CYCLES = SCAN_TICK_CYCLES,
  parameter int HOLD_TICKS  = FRAME_HOLD_TICKS
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rstn,
  output logic [ROWS-1:0]      o_row_n,
  output logic [COLS-1:0]      o_col
);

  localparam logic [FRAME_CNT_W-1:0] HOLD_1 = FRAME_CNT_W'(HOLD_TICKS);
  localparam logic [FRAME_CNT_W-1:0] HOLD_2 = FRAME_CNT_W'(2 * HOLD_TICKS);
  localparam logic [FRAME_CNT_W-1:0] HOLD_3 = FRAME_CNT_W'(3 * HOLD_TICKS);
  localparam logic [FRAME_CNT_W-1:0] HOLD_4 = FRAME_CNT_W'(4 * HOLD_TICKS);

  logic                   scan_tick;
  row_state_t             active_row_state;
  row_state_t             next_row_state;
  matrix_pins_t           pins;
  matrix_pins_t           next_pins;
  logic [1:0]             on_idx;
  logic [1:0]             off_idx;
  logic [ROWS-1:0]        row_word;
  logic [FRAME_CNT_W-1:0] frame_tick_counter;
  logic [FRAME_CNT_W-1:0] next_frame_tick_counter;
  pattern_table_t         column_pattern_table;
  pattern_table_t         next_column_pattern_table;

  ////////////////////////////////////////////////////////////////////////////
  // Tick source
  scan_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .o_tick    (scan_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Row step: one row low at a time keeps a single row's LEDs on at once
  always_comb begin
    next_row_state = active_row_state;
    next_pins      = pins;
    on_idx         = 2'h0;
    off_idx        = 2'h2;
    row_word       = pins.row_n;
    unique case (active_row_state)
      ROW_FIRST: begin
        on_idx  = 2'h0;
        off_idx = 2'h2;
      end
      ROW_SECOND: begin
        on_idx  = 2'h1;
        off_idx = 2'h0;
      end
      ROW_THIRD: begin
        on_idx  = 2'h2;
        off_idx = 2'h1;
      end
    endcase
    if (scan_tick) begin
      unique case (active_row_state)
        ROW_FIRST:  next_row_state = ROW_SECOND;
        ROW_SECOND: next_row_state = ROW_THIRD;
        ROW_THIRD:  next_row_state = ROW_FIRST;
      endcase
      row_word[on_idx]  = 1'b0;
      row_word[off_idx] = 1'b1;
      // Merge under mask so the row bits are never touched by column data
      next_pins = matrix_pins_t'((pins & ~COL_MASK)
                  | ((6'(column_pattern_table[on_idx]) << COL_LSB) & COL_MASK));
      next_pins.row_n = row_word;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      active_row_state <= ROW_FIRST;
      pins.row_n       <= ROW_IDLE_N;
      pins.col         <= COL_RESET;
    end else begin
      active_row_state <= next_row_state;
      pins             <= next_pins;
    end
  end

  assign o_row_n = pins.row_n;
  assign o_col   = pins.col;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: table follows the counter value, like a polling loop
  always_comb begin
    next_frame_tick_counter   = frame_tick_counter;
    next_column_pattern_table = column_pattern_table;
    // A tick landing on the wrap cycle is still counted
    if (frame_tick_counter > HOLD_4) begin
      next_frame_tick_counter = scan_tick ? FRAME_CNT_W'(1) : '0;
    end else if (scan_tick) begin
      next_frame_tick_counter = frame_tick_counter + FRAME_CNT_W'(1);
    end
    if (frame_tick_counter == HOLD_1) begin
      next_column_pattern_table = FRAME_T;
    end else if (frame_tick_counter == HOLD_2) begin
      next_column_pattern_table = FRAME_BLANK;
    end else if (frame_tick_counter == HOLD_3) begin
      next_column_pattern_table = FRAME_I;
    end else if (frame_tick_counter == HOLD_4) begin
      next_column_pattern_table = FRAME_BLANK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      frame_tick_counter   <= '0;
      column_pattern_table <= FRAME_BLANK;
    end else begin
      frame_tick_counter   <= next_frame_tick_counter;
      column_pattern_table <= next_column_pattern_table;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // The gap counter is wide on purpose so a stuck divider cannot wrap into a pass
  logic [31:0] gap_cnt;
  logic        seen_tick;

  // Cycles since the previous tick, for the period check
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      gap_cnt   <= 32'h0;
      seen_tick <= 1'b0;
    end else begin
      gap_cnt   <= scan_tick ? 32'h1 : gap_cnt + 32'h1;
      seen_tick <= seen_tick | scan_tick;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // Building blocks for the row step checks
  sequence s_tick_on(row_state_t r);
    scan_tick && active_row_state == r;
  endsequence

  sequence s_first_row_shown;
    !o_row_n[0] && o_row_n[1] && o_row_n[2];
  endsequence

  a_reset_first_row: assert property (disable iff (1'b0)
    !i_rstn |=> active_row_state == ROW_FIRST)
    else $error("row state not first after reset");

  a_row_advance: assert property (
    s_tick_on(ROW_THIRD) |=> active_row_state == ROW_FIRST)
    else $error("row state did not wrap to first");

  a_first_tick_row: assert property (
    s_tick_on(ROW_FIRST) |=> s_first_row_shown ##1 active_row_state == ROW_SECOND [*1])
    else $error("first row not driven alone");

  a_one_row_low: assert property (
    scan_tick |=> $countones(o_row_n) == ROWS - 1 && !o_row_n[$past(on_idx)])
    else $error("not exactly the current row driven low");

  a_col_from_table: assert property (
    scan_tick |=> o_col == $past(column_pattern_table[on_idx])
      ##1 ($stable(o_col) && $stable(o_row_n)))
    else $error("columns not loaded from table entry");

  // Any change between ticks would light a diode in the wrong row for a cycle
  a_hold_between_ticks: assert property (
    !scan_tick |=> $stable(o_row_n) && $stable(o_col))
    else $error("outputs moved between ticks");

  a_counter_step: assert property (
    scan_tick && frame_tick_counter <= HOLD_4 |=> frame_tick_counter
      == $past(frame_tick_counter) + FRAME_CNT_W'(1))
    else $error("frame counter did not step by one");

  a_t_frame: assert property (
    frame_tick_counter == HOLD_1 |=> column_pattern_table == FRAME_T)
    else $error("T frame not loaded");

  a_blank_frame: assert property (
    frame_tick_counter == HOLD_2 || frame_tick_counter == HOLD_4
      |=> column_pattern_table == FRAME_BLANK)
    else $error("blank frame not loaded");

  a_i_frame: assert property (
    frame_tick_counter == HOLD_3 |=> column_pattern_table == FRAME_I)
    else $error("I frame not loaded");

  a_counter_wrap: assert property (
    frame_tick_counter > HOLD_4 |=> frame_tick_counter <= FRAME_CNT_W'(1))
    else $error("frame counter did not restart");

  a_tick_period: assert property (
    scan_tick && seen_tick |-> gap_cnt == TICK_CYCLES)
    else $error("scan tick spacing wrong");

endmodule

// ---- test/led_matrix_model.sv ----
// Behavioural three by three LED matrix that reports which diodes conduct
`timescale 1ns/1ps
module led_matrix_model
  import led_matrix_pkg::*;
(
  input  wire logic [ROWS-1:0]      i_row_n,
  input  wire logic [COLS-1:0]      i_col,
  output logic      [ROWS*COLS-1:0] o_lit
);
  // A diode lights only with its cathode row low and its anode column high
  always_comb begin
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        o_lit[r*COLS+c] = !i_row_n[r] && i_col[c];
      end
    end
  end
endmodule

// ---- test/led_matrix_row_scanner_bench.sv ----
// Self-checking bench for the LED matrix row scanner with random resets
`timescale 1ns/1ps
module led_matrix_row_scanner_bench;
  import led_matrix_pkg::*;
  // Short tick and hold counts keep a whole frame cycle to 52 clocks
  localparam int TK = 4;
  localparam int HT = 3;
  logic                 i_sys_clk = 1'b0;
  logic                 i_rstn    = 1'b0;
  logic [ROWS-1:0]      o_row_n;
  logic [COLS-1:0]      o_col;
  logic [ROWS*COLS-1:0] lit;
  logic [31:0]          seed      = 32'hE1DD;
  int                   error_cnt = 0;
  int                   compares  = 0;

  led_matrix_row_scanner #(.TICK_CYCLES(TK), .HOLD_TICKS(HT)) DUT (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .o_row_n   (o_row_n),
    .o_col     (o_col)
  );
  led_matrix_model matrix (.i_row_n(o_row_n), .i_col(o_col), .o_lit(lit));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and helpers
  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Column pattern loaded for row r on the tick taken while the frame counter holds c
  function automatic logic [2:0] exp_col(input int c, input int r);
    if (c >= HT && c < 2 * HT) return (r == 0) ? 3'h7 : 3'h2;
    if (c >= 3 * HT && c < 4 * HT) return (r == 1) ? 3'h2 : 3'h7;
    return 3'h0;
  endfunction

  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Follow n ticks from a release of reset; the counter wraps every 4*HT+1 ticks
  task automatic run_ticks(input int n);
    int w;
    logic [2:0] er;
    logic [2:0] ec;
    logic [8:0] el;
    w = 0;
    while (o_row_n === ROW_IDLE_N && w < TK + 4) begin
      @(negedge i_sys_clk);
      w++;
    end
    compares++;
    if (w >= TK + 4) fail("no first row after reset");
    for (int t = 0; t < n; t++) begin
      er = ~(3'h1 << (t % 3));
      ec = exp_col(t % (4 * HT + 1), t % 3);
      el = '0;
      for (int c = 0; c < 3; c++) el[(t % 3) * 3 + c] = ec[c];
      compares += 3;
      if (o_row_n !== er) fail("wrong active row");
      if (o_col !== ec) fail("wrong column pattern");
      if (lit !== el) fail("wrong lit image");
      for (int k = 1; k < TK; k++) begin
        @(negedge i_sys_clk);
        compares++;
        if (o_row_n !== er || o_col !== ec) fail("output moved between ticks");
      end
      @(negedge i_sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: four runs of random length, each ended by a reset at a random phase and length
  initial begin
    repeat (20) @(negedge i_sys_clk);
    repeat (4) begin
      compares++;
      if (o_row_n !== ROW_IDLE_N || o_col !== 3'h0) fail("outputs not idle in reset");
      i_rstn = 1'b1;
      seed = xorshift(seed);
      run_ticks(45 + int'(seed % 40));
      seed = xorshift(seed);
      repeat (int'(seed % TK)) @(negedge i_sys_clk);
      i_rstn = 1'b0;
      seed = xorshift(seed);
      repeat (1 + int'(seed % 8)) @(negedge i_sys_clk);
    end
    print_verdict();
  end

  // Watchdog well past the longest expected run
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    fail("watchdog expired");
    print_verdict();
  end
endmodule
